// File: hw/smbsl_pkg.sv
// package for the two-wire slave register port
package smbsl_pkg;
    localparam logic [3:0] SMBSL_ADDR_HI      = 4'h3;
    localparam int         SMBSL_CLK_PERIOD_NS = 4;
    localparam int         SMBSL_TOUT_MS      = 25;
    localparam int         SMBSL_TOUT_CYC     = SMBSL_TOUT_MS * 1000000 / SMBSL_CLK_PERIOD_NS;
    localparam int         SMBSL_SETUP_NS     = 250;
    localparam int         SMBSL_SETUP_CYC    = (SMBSL_SETUP_NS + SMBSL_CLK_PERIOD_NS - 1) / SMBSL_CLK_PERIOD_NS;
    localparam logic [15:0] SMBSL_PTR_RST     = 16'h0000;

    typedef enum logic [2:0] {
        SMBSL_IDLE,
        SMBSL_ADDR,
        SMBSL_ACK,
        SMBSL_RX,
        SMBSL_TX,
        SMBSL_TXACK
    } smbsl_state_t;

    // register access port towards the register file
    typedef struct packed {
        logic        wr;
        logic [7:0]  ptr;
        logic [15:0] data;
    } smbsl_reg_wr_t;
endpackage

// File: hw/smbsl_port.sv
// two-wire slave port giving a master access to registers through a retained pointer
`timescale 1ns/10ps
module smbsl_port
    import smbsl_pkg::*;
#(
    parameter int TOUT_CYC = SMBSL_TOUT_CYC
) (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst,
    // bus pins
    input  wire logic          scl_in,
    input  wire logic          sda_in,
    output logic               sda_out,
    output logic               sda_oe,
    // address straps
    input  wire logic          addr_strap_bit0,
    input  wire logic          addr_strap_bit1,
    input  wire logic          addr_strap_bit2,
    // register access
    input  wire logic [15:0]   reg_rdata,
    output logic [7:0]         reg_ptr,
    output smbsl_reg_wr_t      reg_wr,
    output logic               bus_busy
);
    localparam int TW = $clog2(TOUT_CYC + 1);

    // two-flop synchronisers; first stage feeds only the second
    logic [1:0] scl_s_q, scl_s_d, sda_s_q, sda_s_d;
    logic [2:0] strap_s1_q, strap_s2_q, strap_s1_d, strap_s2_d;
    logic       scl_p_q, sda_p_q, scl_p_d, sda_p_d;
    logic       drv_lvl_q, drv_lvl_d;

    logic        scl, sda, scl_rise, scl_fall, start_c, stop_c;
    smbsl_state_t st_q, st_d;
    logic [3:0]  bit_q, bit_d;
    logic [7:0]  sh_q, sh_d;
    logic        rd_q, rd_d;
    logic        first_q, first_d;
    logic        hi_q, hi_d;
    logic        have_hi_q, have_hi_d;
    logic [7:0]  hib_q, hib_d;
    logic [7:0]  ptr_q, ptr_d;
    logic        oe_q, oe_d;
    logic        busy_q, busy_d;
    smbsl_reg_wr_t wr_q, wr_d;
    logic [TW-1:0] tout_q, tout_d;
    logic          tout_hit;
    logic [7:0]    tx_b;

    assign scl      = scl_s_q[1];
    assign sda      = sda_s_q[1];
    assign scl_rise = scl & ~scl_p_q;
    assign scl_fall = ~scl & scl_p_q;
    assign start_c  = scl & scl_p_q & sda_p_q & ~sda;
    assign stop_c   = scl & scl_p_q & ~sda_p_q & sda;

    // byte handed to the master; high byte first, no increment across registers
    function automatic logic [7:0] tx_byte(input logic hi, input logic [15:0] d);
        tx_byte = hi ? d[15:8] : d[7:0];
    endfunction

    // fixed upper nibble, then the three strap levels
    function automatic logic addr_hit(input logic [6:0] a, input logic [2:0] s);
        addr_hit = (a == {SMBSL_ADDR_HI, s});
    endfunction

    // named net so the bit slices below come from a value, not a call
    assign tx_b = tx_byte(hi_q, reg_rdata);

    always_comb begin
        scl_s_d   = {scl_s_q[0], scl_in};
        sda_s_d   = {sda_s_q[0], sda_in};
        scl_p_d   = scl;
        sda_p_d   = sda;
        // open drain: the pin register only ever holds low
        drv_lvl_d = 1'b0;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            scl_s_q   <= 2'h3;
            sda_s_q   <= 2'h3;
            scl_p_q   <= 1'b1;
            sda_p_q   <= 1'b1;
            drv_lvl_q <= 1'b0;
        end else begin
            scl_s_q   <= scl_s_d;
            sda_s_q   <= sda_s_d;
            scl_p_q   <= scl_p_d;
            sda_p_q   <= sda_p_d;
            drv_lvl_q <= drv_lvl_d;
        end
    end

    // straps are static but still cross two flops before the address compare
    always_comb begin
        strap_s1_d = {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
        strap_s2_d = strap_s1_q;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strap_s1_q <= 3'h0;
            strap_s2_q <= 3'h0;
        end else begin
            strap_s1_q <= strap_s1_d;
            strap_s2_q <= strap_s2_d;
        end
    end

    // stuck clock counter; any synchronised clock edge or a free bus restarts it
    always_comb begin
        if (scl_rise || scl_fall || !busy_q) begin
            tout_d = '0;
        end else if (tout_hit) begin
            tout_d = tout_q;
        end else begin
            tout_d = tout_q + TW'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tout_q <= '0;
        end else begin
            tout_q <= tout_d;
        end
    end

    // counted while busy, so a stalled foreign transfer also frees the interface
    assign tout_hit = tout_q >= TW'(TOUT_CYC);

    // protocol engine; sda only ever pulled low, the clock is never driven
    always_comb begin
        st_d      = st_q;
        bit_d     = bit_q;
        sh_d      = sh_q;
        rd_d      = rd_q;
        first_d   = first_q;
        hi_d      = hi_q;
        have_hi_d = have_hi_q;
        hib_d     = hib_q;
        ptr_d     = ptr_q;
        oe_d      = oe_q;
        busy_d    = busy_q;
        wr_d      = '{wr: 1'b0, ptr: ptr_q, data: {hib_q, sh_q}};
        if (tout_hit) begin
            st_d   = SMBSL_IDLE;
            oe_d   = 1'b0;
            busy_d = 1'b0;
        end else if (start_c) begin
            // a new START wins over any byte in flight
            st_d   = SMBSL_ADDR;
            bit_d  = 4'h0;
            oe_d   = 1'b0;
            busy_d = 1'b1;
        end else if (stop_c) begin
            // both lines high again after this: the bus is free
            st_d   = SMBSL_IDLE;
            oe_d   = 1'b0;
            busy_d = 1'b0;
        end else begin
            case (st_q)
                SMBSL_IDLE: begin
                    oe_d = 1'b0;
                end
                SMBSL_ADDR, SMBSL_RX: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda};
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall && bit_q == 4'h8) begin
                        if (st_q == SMBSL_ADDR) begin
                            if (addr_hit(sh_q[7:1], strap_s2_q)) begin
                                oe_d      = 1'b1;
                                rd_d      = sh_q[0];
                                first_d   = 1'b1;
                                hi_d      = 1'b1;
                                have_hi_d = 1'b0;
                                st_d      = SMBSL_ACK;
                            end else begin
                                // foreign address: stay off the line until the next START
                                st_d = SMBSL_IDLE;
                            end
                        end else begin
                            oe_d = 1'b1;
                            st_d = SMBSL_ACK;
                            if (first_q) begin
                                ptr_d   = sh_q;
                                first_d = 1'b0;
                            end else if (!have_hi_q) begin
                                hib_d     = sh_q;
                                have_hi_d = 1'b1;
                            end else begin
                                wr_d      = '{wr: 1'b1, ptr: ptr_q, data: {hib_q, sh_q}};
                                have_hi_d = 1'b0;
                            end
                        end
                    end
                end
                SMBSL_ACK: begin
                    // held through the ninth clock high; on its fall dropped for a write, set to the first data bit for a read
                    if (scl_fall) begin
                        bit_d = 4'h0;
                        if (rd_q) begin
                            st_d = SMBSL_TX;
                            // register data is taken here, at least a whole address byte after the pointer has settled
                            oe_d = ~tx_b[7];
                            sh_d = {tx_b[6:0], 1'b1};
                            hi_d = ~hi_q;
                        end else begin
                            st_d = SMBSL_RX;
                            oe_d = 1'b0;
                        end
                    end
                end
                SMBSL_TX: begin
                    if (scl_rise) begin
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_q == 4'h8) begin
                            oe_d = 1'b0;
                            st_d = SMBSL_TXACK;
                        end else begin
                            // next bit moves only after a synchronised fall, never with the clock high
                            oe_d = ~sh_q[7];
                            sh_d = {sh_q[6:0], 1'b1};
                        end
                    end
                end
                SMBSL_TXACK: begin
                    if (scl_rise) begin
                        // not-acknowledge leaves the line released
                        st_d = sda ? SMBSL_IDLE : SMBSL_ACK;
                    end
                end
                default: st_d = SMBSL_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q      <= SMBSL_IDLE;
            bit_q     <= 4'h0;
            sh_q      <= 8'h00;
            rd_q      <= 1'b0;
            first_q   <= 1'b0;
            hi_q      <= 1'b1;
            have_hi_q <= 1'b0;
            hib_q     <= 8'h00;
            ptr_q     <= SMBSL_PTR_RST[7:0];
            oe_q      <= 1'b0;
            busy_q    <= 1'b0;
            wr_q      <= '0;
        end else begin
            st_q      <= st_d;
            bit_q     <= bit_d;
            sh_q      <= sh_d;
            rd_q      <= rd_d;
            first_q   <= first_d;
            hi_q      <= hi_d;
            have_hi_q <= have_hi_d;
            hib_q     <= hib_d;
            ptr_q     <= ptr_d;
            oe_q      <= oe_d;
            busy_q    <= busy_d;
            wr_q      <= wr_d;
        end
    end

    assign sda_out  = drv_lvl_q;
    assign sda_oe   = oe_q;
    assign reg_ptr  = ptr_q;
    assign reg_wr   = wr_q;
    assign bus_busy = busy_q;
endmodule

// File: testbench/smbsl_port_monitor.sv
// assertions on the pins of the two-wire slave port
`timescale 1ns/10ps
module smbsl_port_monitor
    import smbsl_pkg::*;
#(
    parameter int TOUT_CYC = SMBSL_TOUT_CYC
) (
    // clock and reset
    input wire logic          ref_clk,
    input wire logic          rst,
    // bus pins
    input wire logic          scl_in,
    input wire logic          sda_in,
    input wire logic          sda_out,
    input wire logic          sda_oe,
    // register side
    input wire logic [7:0]    reg_ptr,
    input wire smbsl_reg_wr_t reg_wr,
    input wire logic          bus_busy
);
    // cycles with no clock pin edge while engaged
    int   cnt_d;
    int   cnt_q;
    logic scl_q;
    always_comb begin
        cnt_d = ((bus_busy || sda_oe) && scl_in == scl_q) ? cnt_q + 1 : 0;
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 0;
            scl_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            scl_q <= scl_in;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_open_drain: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    a_start_busy: assert property ($past(scl_in) && scl_in && $fell(sda_in) |-> ##[1:8] bus_busy)
        else $error("start not taken");
    a_stop_release: assert property ($past(scl_in) && scl_in && $rose(sda_in) |-> ##[1:8] (!sda_oe && !bus_busy))
        else $error("stop did not release");
    // slack covers the pin synchroniser
    a_timeout_free: assert property (cnt_q <= TOUT_CYC + 16)
        else $error("stuck clock not timed out");
    a_hold_high: assert property ($past(scl_in) && scl_in && cnt_q < TOUT_CYC |-> $stable(sda_oe))
        else $error("data moved while clock high");
    a_wr_pulse: assert property (reg_wr.wr |=> !reg_wr.wr [*2])
        else $error("write strobe too long");
    a_wr_ptr: assert property (reg_wr.wr |-> reg_wr.ptr == reg_ptr)
        else $error("write off the pointer");
    a_ptr_kept: assert property (!bus_busy && !$past(bus_busy) |-> $stable(reg_ptr))
        else $error("pointer moved while idle");
endmodule

// File: testbench/smbsl_master.sv
// bus master model: makes the clock, starts, stops, shifts bytes
`timescale 1ns/10ps
module smbsl_master (
    // clock
    input wire logic ref_clk,
    // bus; data is open drain, 1 releases to the pull-up
    output logic     scl = 1'b1,
    output logic     sda_drv = 1'b1,
    input wire logic sda_line
);
    // a quarter of the 80 ns bus period
    task automatic qtr();
        repeat (5) @(posedge ref_clk);
    endtask
    task automatic start();
        sda_drv <= 1'b1;
        qtr();
        scl <= 1'b1;
        qtr();
        sda_drv <= 1'b0;
        qtr();
        scl <= 1'b0;
        qtr();
    endtask
    task automatic stop();
        sda_drv <= 1'b0;
        qtr();
        scl <= 1'b1;
        qtr();
        sda_drv <= 1'b1;
        repeat (4) qtr();
    endtask
    // eight bits then the acknowledge clock; data moves only with clock low
    task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic ack);
        logic [8:0] s;
        logic [8:0] g;
        s = {d, mack};
        for (int i = 8; i >= 0; i--) begin
            sda_drv <= s[i];
            qtr();
            scl <= 1'b1;
            qtr();
            g[i] = sda_line;
            qtr();
            scl <= 1'b0;
            qtr();
        end
        r = g[8:1];
        ack = g[0];
    endtask
endmodule

// File: testbench/smbsl_port_test.sv
// self-checking bench for the two-wire slave port
`timescale 1ns/10ps
module smbsl_port_test import smbsl_pkg::*;;
    localparam int         TOUT = 2000;
    localparam logic [6:0] DEV  = {SMBSL_ADDR_HI, 3'b101};
    logic          ref_clk;
    logic          rst;
    logic          scl;
    logic          sda_drv;
    logic          sda_line;
    logic          sda_out;
    logic          sda_oe;
    logic [2:0]    strap;
    logic [15:0]   reg_rdata;
    logic [7:0]    reg_ptr;
    smbsl_reg_wr_t reg_wr;
    logic          bus_busy;
    logic [15:0]   regs [256];
    logic [7:0]    rd;
    logic          ak;
    int            errors;
    int            n_tests;
    assign sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);
    smbsl_master i_smbsl_master (.ref_clk(ref_clk), .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
    smbsl_port #(.TOUT_CYC(TOUT)) i_smbsl_port (.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
        .addr_strap_bit2(strap[2]), .reg_rdata(reg_rdata), .reg_ptr(reg_ptr), .reg_wr(reg_wr), .bus_busy(bus_busy));
    // register file beside the port
    always @(posedge ref_clk) begin
        if (reg_wr.wr) begin
            regs[reg_wr.ptr] <= reg_wr.data;
        end
        reg_rdata <= regs[reg_ptr];
    end
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic t_write(input logic [7:0] p, input logic [15:0] w);
        i_smbsl_master.start();
        i_smbsl_master.xfer({DEV, 1'b0}, 1'b1, rd, ak);
        check(ak, 1'b0);
        i_smbsl_master.xfer(p, 1'b1, rd, ak);
        check(ak, 1'b0);
        i_smbsl_master.xfer(w[15:8], 1'b1, rd, ak);
        check(ak, 1'b0);
        i_smbsl_master.xfer(w[7:0], 1'b1, rd, ak);
        check(ak, 1'b0);
        i_smbsl_master.stop();
        check(regs[p], w);
        check(reg_ptr, p);
    endtask
    // three bytes read: the pointer never advances
    task automatic t_read(input logic [15:0] w);
        logic [7:0] hi;
        i_smbsl_master.start();
        i_smbsl_master.xfer({DEV, 1'b1}, 1'b1, rd, ak);
        check(ak, 1'b0);
        i_smbsl_master.xfer(8'hFF, 1'b0, hi, ak);
        i_smbsl_master.xfer(8'hFF, 1'b0, rd, ak);
        check({hi, rd}, w);
        i_smbsl_master.xfer(8'hFF, 1'b1, rd, ak);
        check(rd, w[15:8]);
        i_smbsl_master.stop();
        check({sda_oe, bus_busy}, 2'b00);
    endtask
    task automatic t_bad_addr();
        logic [20:0] bad;
        bad = {7'h1C, 7'h5D, 7'h19};
        for (int i = 0; i < 3; i++) begin
            i_smbsl_master.start();
            i_smbsl_master.xfer({bad[i*7+:7], 1'b0}, 1'b1, rd, ak);
            check(ak, 1'b1);
            i_smbsl_master.stop();
        end
    endtask
    // a lone high byte followed by a repeated start must not write
    task automatic t_restart(input logic [7:0] p, input logic [15:0] w);
        i_smbsl_master.start();
        i_smbsl_master.xfer({DEV, 1'b0}, 1'b1, rd, ak);
        i_smbsl_master.xfer(p, 1'b1, rd, ak);
        i_smbsl_master.xfer(8'h00, 1'b1, rd, ak);
        i_smbsl_master.start();
        i_smbsl_master.xfer({DEV, 1'b1}, 1'b1, rd, ak);
        check(ak, 1'b0);
        i_smbsl_master.xfer(8'hFF, 1'b1, rd, ak);
        check(rd, w[15:8]);
        i_smbsl_master.stop();
        check(regs[p], w);
    endtask
    task automatic t_timeout();
        i_smbsl_master.start();
        i_smbsl_master.xfer({DEV, 1'b0}, 1'b1, rd, ak);
        repeat (TOUT + 40) @(posedge ref_clk);
        check({sda_oe, bus_busy}, 2'b00);
        i_smbsl_master.stop();
        t_write(8'h03, 16'h0F0F);
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge ref_clk);
        errors++;
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        strap = 3'b101;
        errors = 0;
        n_tests = 0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        t_write(8'h07, 16'h5AC3);
        t_write(8'h05, 16'hA53C);
        t_read(16'hA53C);
        t_bad_addr();
        t_restart(8'h07, 16'h5AC3);
        t_timeout();
        tally_and_finish();
    end
endmodule
bind smbsl_port smbsl_port_monitor #(.TOUT_CYC(TOUT_CYC)) i_smbsl_port_monitor (.ref_clk(ref_clk), .rst(rst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
    .bus_busy(bus_busy));
